// ===== rtl/cbm_unit.sv
// carry and zero flag bit manipulation datapath
`timescale 1ns/1ps
`default_nettype none
module cbm_unit
  import cbm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // request
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [2:0] bit_pos,
  input wire logic [7:0] field_mask,
  input wire logic operand_is_mem,
  input wire logic [7:0] source_operand,
  input wire logic [7:0] source_register,
  // flags in
  input wire logic carry_in,
  input wire logic zero_in,
  // results
  output logic done,
  output logic illegal,
  output logic carry_we,
  output logic carry_out,
  output logic operand_we,
  output logic [7:0] operand_out,
  output logic reg_we,
  output logic [7:0] reg_out,
  output logic branch_taken,
  output logic call_taken
);
  // ----------------------------------------------------------------
  // combinational datapath
  // ----------------------------------------------------------------
  logic sel_bit;
  logic [7:0] bit_mask;
  logic [7:0] fld_extract;
  logic [7:0] fld_insert;
  logic done_next, illegal_next, carry_we_next, carry_next;
  logic operand_we_next, reg_we_next, branch_next, call_next;
  logic [7:0] operand_next, reg_next;
  logic done_reg, illegal_reg, carry_we_reg, carry_reg;
  logic operand_we_reg, reg_we_reg, branch_reg, call_reg;
  logic [7:0] operand_reg, reg_reg;
  cbm_op_t op;

  assign op = cbm_op_t'(op_code);
  assign sel_bit = cbm_get_bit(source_operand, bit_pos);
  assign bit_mask = 8'h01 << bit_pos;

  cbm_field u_field (
    .field_mask(field_mask),
    .mem_byte(source_operand),
    .reg_byte(source_register),
    .extracted(fld_extract),
    .inserted(fld_insert)
  );

  // write value v into the selected bit only
  function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [7:0] m,
                                         input logic v);
    put_bit = v ? (b | m) : (b & ~m);
  endfunction : put_bit

  always_comb
  begin
    // defaults keep every destination untouched
    done_next = 1'b0;
    illegal_next = 1'b0;
    carry_we_next = 1'b0;
    carry_next = carry_in;
    operand_we_next = 1'b0;
    operand_next = source_operand;
    reg_we_next = 1'b0;
    reg_next = source_register;
    branch_next = 1'b0;
    call_next = 1'b0;
    if (op_valid)
    begin
      done_next = 1'b1;
      case (op)
        CBM_OP_CARRY_OR_INV_BIT:
        begin
          carry_we_next = 1'b1;
          carry_next = carry_in | ~sel_bit;
        end
        CBM_OP_CARRY_XOR_BIT:
        begin
          carry_we_next = 1'b1;
          carry_next = carry_in ^ sel_bit;
        end
        CBM_OP_CARRY_XOR_INV_BIT:
        begin
          carry_we_next = 1'b1;
          carry_next = carry_in ^ ~sel_bit;
        end
        CBM_OP_BIT_TO_CARRY:
        begin
          carry_we_next = 1'b1;
          carry_next = sel_bit;
        end
        CBM_OP_INV_BIT_TO_CARRY:
        begin
          carry_we_next = 1'b1;
          carry_next = ~sel_bit;
        end
        CBM_OP_CARRY_TO_BIT:
        begin
          operand_we_next = 1'b1;
          operand_next = put_bit(source_operand, bit_mask, carry_in);
        end
        CBM_OP_INV_CARRY_TO_BIT:
        begin
          operand_we_next = 1'b1;
          operand_next = put_bit(source_operand, bit_mask, ~carry_in);
        end
        CBM_OP_ZERO_TO_BIT, CBM_OP_INV_ZERO_TO_BIT:
        begin
          // a register operand is refused and nothing is written
          if (operand_is_mem)
          begin
            operand_we_next = 1'b1;
            operand_next = put_bit(source_operand, bit_mask,
                                   (op == CBM_OP_ZERO_TO_BIT) ? zero_in : ~zero_in);
          end
          else
          begin
            illegal_next = 1'b1;
          end
        end
        CBM_OP_FIELD_LOAD:
        begin
          if (operand_is_mem)
          begin
            reg_we_next = 1'b1;
            reg_next = fld_extract;
          end
          else
          begin
            illegal_next = 1'b1;
          end
        end
        CBM_OP_FIELD_STORE:
        begin
          if (operand_is_mem)
          begin
            operand_we_next = 1'b1;
            operand_next = fld_insert;
          end
          else
          begin
            illegal_next = 1'b1;
          end
        end
        CBM_OP_BRANCH_IF_SET, CBM_OP_BRANCH_IF_CLEAR,
        CBM_OP_CALL_IF_SET, CBM_OP_CALL_IF_CLEAR:
        begin
          if (!operand_is_mem)
          begin
            illegal_next = 1'b1;
          end
          else if (op == CBM_OP_BRANCH_IF_SET)
          begin
            branch_next = sel_bit;
          end
          else if (op == CBM_OP_BRANCH_IF_CLEAR)
          begin
            branch_next = ~sel_bit;
          end
          else if (op == CBM_OP_CALL_IF_SET)
          begin
            call_next = sel_bit;
          end
          else
          begin
            call_next = ~sel_bit;
          end
        end
        default:
        begin
          illegal_next = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // result registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      done_reg <= 1'b0;
      illegal_reg <= 1'b0;
      carry_we_reg <= 1'b0;
      carry_reg <= CBM_FLAG_RST;
      operand_we_reg <= 1'b0;
      operand_reg <= CBM_BYTE_RST;
      reg_we_reg <= 1'b0;
      reg_reg <= CBM_BYTE_RST;
      branch_reg <= 1'b0;
      call_reg <= 1'b0;
    end
    else
    begin
      done_reg <= done_next;
      illegal_reg <= illegal_next;
      carry_we_reg <= carry_we_next;
      carry_reg <= carry_next;
      operand_we_reg <= operand_we_next;
      operand_reg <= operand_next;
      reg_we_reg <= reg_we_next;
      reg_reg <= reg_next;
      branch_reg <= branch_next;
      call_reg <= call_next;
    end
  end

  assign done = done_reg;
  assign illegal = illegal_reg;
  assign carry_we = carry_we_reg;
  assign carry_out = carry_reg;
  assign operand_we = operand_we_reg;
  assign operand_out = operand_reg;
  assign reg_we = reg_we_reg;
  assign reg_out = reg_reg;
  assign branch_taken = branch_reg;
  assign call_taken = call_reg;
endmodule : cbm_unit
`default_nettype wire

// ===== rtl/cbm_pkg.sv
// package for the carry bit manipulation unit
package cbm_pkg;
  // ----------------------------------------------------------------
  // operation codes and widths
  // ----------------------------------------------------------------
  localparam int unsigned CBM_BYTE_W = 8;
  localparam int unsigned CBM_POS_W = 3;
  localparam int unsigned CBM_OP_W = 4;
  localparam logic CBM_FLAG_RST = 1'b0;
  localparam logic [7:0] CBM_BYTE_RST = 8'h00;

  typedef enum logic [3:0] {
    CBM_OP_NONE = 4'h0,
    CBM_OP_CARRY_OR_INV_BIT = 4'h1,
    CBM_OP_CARRY_XOR_BIT = 4'h2,
    CBM_OP_CARRY_XOR_INV_BIT = 4'h3,
    CBM_OP_BIT_TO_CARRY = 4'h4,
    CBM_OP_INV_BIT_TO_CARRY = 4'h5,
    CBM_OP_CARRY_TO_BIT = 4'h6,
    CBM_OP_ZERO_TO_BIT = 4'h7,
    CBM_OP_INV_CARRY_TO_BIT = 4'h8,
    CBM_OP_INV_ZERO_TO_BIT = 4'h9,
    CBM_OP_FIELD_LOAD = 4'ha,
    CBM_OP_FIELD_STORE = 4'hb,
    CBM_OP_BRANCH_IF_SET = 4'hc,
    CBM_OP_BRANCH_IF_CLEAR = 4'hd,
    CBM_OP_CALL_IF_SET = 4'he,
    CBM_OP_CALL_IF_CLEAR = 4'hf
  } cbm_op_t;

  // select one bit of a byte by a 3-bit position
  function automatic logic cbm_get_bit(input logic [7:0] b, input logic [2:0] pos);
    cbm_get_bit = b[pos];
  endfunction : cbm_get_bit
endpackage : cbm_pkg

// ===== rtl/cbm_field.sv
// bit field extract and insert for one byte under a mask
`timescale 1ns/1ps
`default_nettype none
module cbm_field
  import cbm_pkg::*;
(
  // field description
  input wire logic [7:0] field_mask,
  // operands
  input wire logic [7:0] mem_byte,
  input wire logic [7:0] reg_byte,
  // results
  output logic [7:0] extracted,
  output logic [7:0] inserted
);
  // ----------------------------------------------------------------
  // shift by the lowest set bit of the mask
  // ----------------------------------------------------------------
  logic [2:0] shift;

  always_comb
  begin
    shift = 3'd0;
    for (int i = 7; i >= 0; i--)
    begin
      if (field_mask[i])
      begin
        shift = 3'(i);
      end
    end
  end

  // an empty mask extracts zero and leaves the byte as it was
  always_comb
  begin
    extracted = (mem_byte & field_mask) >> shift;
    inserted = (mem_byte & ~field_mask) | ((reg_byte << shift) & field_mask);
  end
endmodule : cbm_field
`default_nettype wire

// ===== tb/cbm_unit_properties.sv
// concurrent checks on the ports of the carry bit manipulation unit
`timescale 1ns/1ps
`default_nettype none
module cbm_unit_properties
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // request
  input wire logic op_valid,
  input wire logic [3:0] op_code,
  input wire logic [2:0] bit_pos,
  input wire logic operand_is_mem,
  input wire logic [7:0] source_operand,
  input wire logic carry_in,
  input wire logic zero_in,
  // results
  input wire logic illegal,
  input wire logic carry_we,
  input wire logic carry_out,
  input wire logic operand_we,
  input wire logic [7:0] operand_out,
  input wire logic reg_we,
  input wire logic branch_taken,
  input wire logic call_taken
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic sel;
  logic [7:0] msk;
  logic go;
  assign sel = source_operand[bit_pos];
  assign msk = 8'h01 << bit_pos;
  assign go = op_valid & nrst;
  // one bit replaced, every other bit kept
  function automatic logic [7:0] put(input logic [7:0] b, input logic [7:0] m, input logic v);
    return (b & ~m) | (m & {8{v}});
  endfunction : put
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  or_inv_a: assert property (go && op_code == 4'h1 |=> carry_we &&
    carry_out == ($past(carry_in) | !$past(sel))) else $error("or inverted bit wrong");
  xor_bit_a: assert property (go && op_code == 4'h2 |=> carry_we &&
    carry_out == ($past(carry_in) ^ $past(sel))) else $error("xor bit wrong");
  xor_inv_a: assert property (go && op_code == 4'h3 |=> carry_we &&
    carry_out == ($past(carry_in) ^ !$past(sel))) else $error("xor inverted bit wrong");
  bit_load_a: assert property (go && op_code == 4'h4 |=> carry_we &&
    carry_out == $past(sel)) else $error("bit load wrong");
  inv_load_a: assert property (go && op_code == 4'h5 |=> carry_we &&
    carry_out == !$past(sel)) else $error("inverted bit load wrong");
  carry_store_a: assert property (go && op_code == 4'h6 |=> operand_we &&
    operand_out == put($past(source_operand), $past(msk), $past(carry_in)))
    else $error("carry store wrong");
  zero_store_a: assert property (go && op_code == 4'h7 && operand_is_mem |=>
    operand_out == put($past(source_operand), $past(msk), $past(zero_in)))
    else $error("zero store wrong");
  mem_only_a: assert property (go && !operand_is_mem && op_code inside {4'h7, 4'h9}
    |=> illegal && !operand_we) else $error("register operand accepted");
  bit_branch_a: assert property (go && operand_is_mem && op_code == 4'hc |=>
    branch_taken == $past(sel) && !call_taken) else $error("branch condition wrong");
  flags_only_a: assert property (go && op_code inside {[4'h1:4'h5]} |=>
    !operand_we && !reg_we && !branch_taken) else $error("carry op wrote elsewhere");
  c_store: cover property (go && op_code == 4'h8 ##1 operand_we);
  c_refuse: cover property (go && op_code == 4'h9 ##1 illegal);
  c_call: cover property (go && op_code == 4'hf ##1 call_taken);
endmodule : cbm_unit_properties
bind cbm_unit cbm_unit_properties u_props (.clk_sys, .nrst, .op_valid, .op_code,
  .bit_pos, .operand_is_mem, .source_operand, .carry_in, .zero_in, .illegal, .carry_we,
  .carry_out, .operand_we, .operand_out, .reg_we, .branch_taken, .call_taken);
`default_nettype wire

// ===== tb/cbm_unit_tb_top.sv
// self-checking testbench for the carry bit manipulation unit
`timescale 1ns/1ps
`default_nettype none
module cbm_unit_tb_top;
  logic clk_sys = 1'b0, nrst = 1'b0, op_valid = 1'b0, operand_is_mem = 1'b0;
  logic carry_in = 1'b0, zero_in = 1'b0;
  logic [3:0] op_code = 4'h0;
  logic [2:0] bit_pos = 3'h0;
  logic [7:0] field_mask = 8'h00, source_operand = 8'h00, source_register = 8'h00;
  logic done, illegal, carry_we, carry_out, operand_we, reg_we, branch_taken, call_taken;
  logic [7:0] operand_out, reg_out;
  int num_errors = 0, num_checks = 0;
  cbm_unit dut (.clk_sys, .nrst, .op_valid, .op_code, .bit_pos, .field_mask,
    .operand_is_mem, .source_operand, .source_register, .carry_in, .zero_in, .done,
    .illegal, .carry_we, .carry_out, .operand_we, .operand_out, .reg_we, .reg_out,
    .branch_taken, .call_taken);
  initial forever #5 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // drivers and compare
  // ----------------------------------------------------------------
  // results are read one cycle after the request, when they stand
  task automatic run(input logic [3:0] c, input logic [2:0] p, input logic m,
    input logic [7:0] s);
    @(posedge clk_sys);
    #1;
    {op_valid, op_code, bit_pos, operand_is_mem, source_operand} = {1'b1, c, p, m, s};
    @(posedge clk_sys);
    #1;
    op_valid = 1'b0;
  endtask : run
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_carry();
    logic [7:0] s = 8'h5a;
    logic b;
    logic [4:0] e;
    for (int k = 1; k <= 5; k++)
      for (int i = 0; i < 16; i++)
      begin
        carry_in = i[3];
        run(k[3:0], i[2:0], i[0], s);
        b = s[i[2:0]];
        e = {~b, b, i[3] ^ ~b, i[3] ^ b, i[3] | ~b};
        chk("carry", e[k - 1], carry_out);
        chk("flag only", 8'h01, carry_we & done & ~illegal & ~operand_we & ~reg_we);
      end
  endtask : t_carry
  task automatic t_store();
    logic [3:0] v;
    logic [7:0] x;
    for (int k = 6; k <= 9; k++)
      for (int i = 0; i < 16; i++)
      begin
        {carry_in, zero_in} = {i[3], ~i[3]};
        run(k[3:0], i[2:0], (k == 7 || k == 9) ? 1'b1 : i[0], 8'h3c);
        v = {i[3], ~i[3], ~i[3], i[3]};
        x = (8'h3c & ~(8'h01 << i[2:0])) | ({7'h0, v[k - 6]} << i[2:0]);
        chk("byte", x, operand_out);
        chk("byte only", 1, operand_we & ~carry_we & ~reg_we);
      end
  endtask : t_store
  task automatic t_refuse();
    for (int k = 0; k < 16; k++)
      if (!(k inside {[1:6], 8}))
      begin
        run(k[3:0], 3'h1, 1'b0, 8'hff);
        chk("refused", 1, illegal & done & ~operand_we & ~reg_we & ~branch_taken
          & ~call_taken);
      end
  endtask : t_refuse
  // a reset in mid-run must clear every output even with a request present
  task automatic t_reset();
    logic [7:0] f;
    @(posedge clk_sys);
    #1;
    {nrst, op_valid, op_code, carry_in, source_operand} = {1'b0, 1'b1, 4'h6, 1'b1, 8'h00};
    @(posedge clk_sys);
    #1;
    f = {done, illegal, carry_we, carry_out, operand_we, reg_we, branch_taken, call_taken};
    chk("reset flags", 8'h00, f);
    chk("reset bytes", 8'h00, operand_out | reg_out);
    {nrst, op_valid} = 2'h2;
  endtask : t_reset
  task automatic t_field();
    {field_mask, source_register} = {8'h38, 8'h05};
    run(4'ha, 3'h0, 1'b1, 8'hd6);
    chk("field load", 8'h02, reg_out);
    chk("load we", 8'h02, {6'h00, reg_we, operand_we});
    run(4'hb, 3'h0, 1'b1, 8'hd6);
    chk("field store", 8'hee, operand_out);
    chk("store we", 8'h02, {6'h00, operand_we, reg_we});
  endtask : t_field
  task automatic t_branch();
    logic [7:0] s = 8'ha5;
    logic w;
    for (int k = 12; k <= 15; k++)
      for (int p = 0; p < 8; p++)
      begin
        run(k[3:0], p[2:0], 1'b1, s);
        w = s[p] ^ k[0];
        chk("branch", (k < 14) & w, branch_taken);
        chk("call", (k >= 14) & w, call_taken);
      end
  endtask : t_branch
  initial
  begin
    #20000;
    num_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    t_carry();
    t_store();
    t_refuse();
    t_reset();
    t_field();
    t_branch();
    report_and_stop();
  end
endmodule : cbm_unit_tb_top
`default_nettype wire
